/* File: ftc_transport_controller.sv */
// Purpose: moves fis frames between link core and memory
// Assumes: link core and memory on clk; software aligns bases to 512 bytes
// Notes: one instance per side; only the attached phy differs
`timescale 1ns/1ps
`default_nettype none
module ftc_transport_controller #(parameter int ADDR_W = 8) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// axi4-lite register slave
	input wire logic [ADDR_W-1:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [ADDR_W-1:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	// axi4 memory master
	output logic [31:0] m_araddr,
	output logic [7:0] m_arlen,
	output logic [2:0] m_arsize,
	output logic [1:0] m_arburst,
	output logic m_arvalid,
	input wire logic m_arready,
	input wire logic [ftc_pkg::DMA_W-1:0] m_rdata,
	input wire logic m_rlast,
	input wire logic m_rvalid,
	output logic m_rready,
	output logic [31:0] m_awaddr,
	output logic [7:0] m_awlen,
	output logic [2:0] m_awsize,
	output logic [1:0] m_awburst,
	output logic m_awvalid,
	input wire logic m_awready,
	output logic [ftc_pkg::DMA_W-1:0] m_wdata,
	output logic [ftc_pkg::DMA_W/8-1:0] m_wstrb,
	output logic m_wlast,
	output logic m_wvalid,
	input wire logic m_wready,
	input wire logic [1:0] m_bresp,
	input wire logic m_bvalid,
	output logic m_bready,
	// link core frame ports
	output logic [ftc_pkg::WORD_W-1:0] tx_data,
	output logic tx_sof,
	output logic tx_eof,
	output logic tx_valid,
	input wire logic tx_ready,
	input wire logic [ftc_pkg::WORD_W-1:0] rx_data,
	input wire logic rx_sof,
	input wire logic rx_eof,
	input wire logic rx_valid,
	output logic rx_ready,
	input wire logic [31:0] link_err_code,
	input wire logic [31:0] link_version,
	output logic link_reset,
	// interrupts
	output logic core_to_cpu_irq,
	output logic cpu_to_core_irq
);
	import ftc_pkg::*;
	typedef enum logic [2:0] {T_IDLE, T_HDR, T_AR, T_R, T_W} ftc_tx_t;
	typedef enum logic [1:0] {R_IDLE, R_AW, R_FILL, R_RESP} ftc_rx_t;
	ftc_regs_if cfg();
	ftc_tx_t tx_st;
	ftc_rx_t rx_st;
	logic sreset;
	logic tx_start;
	logic tx_take;
	logic tx_beat_end;
	logic tx_done;
	logic [CTRL_CNT_W-1:0] tx_left;
	logic [CTRL_CNT_W-1:0] tx_left_next;
	logic [DMA_W-1:0] tx_shift;
	logic [2:0] tx_idx;
	logic tx_lastb;
	logic tx_first;
	logic [31:0] tx_addr;
	logic rx_push;
	logic rx_word;
	logic rx_done;
	logic rx_eof_seen;
	logic rx_nondata;
	logic [2:0] rx_idx;
	logic [3:0] rx_beat;
	logic [31:0] rx_addr;
	logic rx_cnt_type_reg;
	logic [CNT_W-1:0] rx_cnt_reg;
	logic [31:0] err_reg;
	ftc_reg_bank #(.ADDR_W(ADDR_W)) u_bank (
		.clk(clk), .rst(rst),
		.s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
		.s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
		.s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
		.s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
		.s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
		.cfg(cfg)
	);
	// status towards the bank; version comes straight from the link core
	assign cfg.err_code = err_reg;
	assign cfg.version = link_version;
	assign cfg.rx_type = rx_cnt_type_reg;
	assign cfg.rx_count = rx_cnt_reg;
	// reset level held while control bit 31 stays set; no bus abort is done
	assign sreset = cfg.ctrl_val[CTRL_RESET_BIT];
	assign link_reset = sreset;
	// fixed burst shape for both directions
	assign m_arlen = AXI_LEN;
	assign m_arsize = AXI_SIZE;
	assign m_arburst = AXI_INCR;
	assign m_awlen = AXI_LEN;
	assign m_awsize = AXI_SIZE;
	assign m_awburst = AXI_INCR;
	assign m_wstrb = '1;
	assign m_wlast = rx_beat == LAST_BEAT;
	// transmit side handshakes
	assign tx_start = tx_st == T_IDLE && cfg.ctrl_wr && cfg.ctrl_val[CTRL_START_BIT] && !sreset;
	assign tx_left_next = tx_left == '0 ? '0 : tx_left - 16'h0001;
	assign tx_take = tx_left == '0 || tx_ready; // empty words of the last beat are dropped
	assign tx_beat_end = tx_idx == 3'h7 || tx_left == '0;
	assign tx_valid = tx_st == T_HDR || (tx_st == T_W && tx_left != '0);
	assign tx_data = tx_shift[WORD_W-1:0];
	assign tx_sof = tx_first;
	assign tx_eof = tx_st == T_HDR ? tx_left == '0 : tx_left == 16'h0001;
	assign m_arvalid = tx_st == T_AR;
	assign m_araddr = tx_addr;
	assign m_rready = tx_st == T_R; // one beat held, memory stalls meanwhile
	assign tx_done = (tx_st == T_HDR && tx_ready && tx_left == '0) ||
		(tx_st == T_W && tx_take && tx_beat_end && tx_lastb && tx_left_next == '0);
	// transmit sequencer: header for data frames only, then bursts unpacked word by word
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_st <= T_IDLE;
			tx_left <= '0;
			tx_shift <= '0;
			tx_idx <= 3'h0;
			tx_lastb <= 1'b0;
			tx_first <= 1'b0;
			tx_addr <= REG_RESET;
		end else if (sreset) begin
			tx_st <= T_IDLE;
			tx_first <= 1'b0;
		end else begin
			unique case (tx_st)
				T_IDLE: if (tx_start) begin
					tx_left <= cfg.ctrl_val[CTRL_CNT_W-1:0];
					tx_addr <= cfg.tx_base;
					tx_first <= 1'b1;
					if (cfg.ctrl_val[CTRL_DATA_BIT]) begin
						tx_shift <= {{(DMA_W-WORD_W){1'b0}}, DATA_FIS_HDR};
						tx_st <= T_HDR;
					end else if (cfg.ctrl_val[CTRL_CNT_W-1:0] != '0) begin
						tx_st <= T_AR;
					end else begin
						tx_first <= 1'b0;
					end
				end
				T_HDR: if (tx_ready) begin
					tx_first <= 1'b0;
					tx_st <= tx_left == '0 ? T_IDLE : T_AR;
				end
				T_AR: if (m_arready) begin
					tx_st <= T_R;
				end
				T_R: if (m_rvalid) begin
					tx_shift <= m_rdata;
					tx_idx <= 3'h0;
					tx_lastb <= m_rlast;
					tx_st <= T_W;
				end
				T_W: if (tx_take) begin
					tx_shift <= tx_shift >> WORD_W;
					tx_idx <= tx_idx + 3'h1;
					tx_left <= tx_left_next;
					if (tx_left != '0) begin
						tx_first <= 1'b0;
					end
					if (tx_beat_end) begin
						if (!tx_lastb) begin
							tx_st <= T_R;
						end else if (tx_left_next == '0) begin
							tx_st <= T_IDLE;
						end else begin
							tx_addr <= tx_addr + BURST_BYTES;
							tx_st <= T_AR;
						end
					end
				end
			endcase
		end
	end
	// receive side handshakes; ready drops while a packed beat waits
	assign rx_ready = rx_st == R_IDLE || (rx_st == R_FILL && !m_wvalid && !rx_eof_seen);
	assign rx_word = rx_valid && rx_ready && !sreset && (rx_st != R_IDLE || rx_sof);
	assign rx_push = rx_word || (rx_st == R_FILL && !m_wvalid && rx_eof_seen);
	assign m_awvalid = rx_st == R_AW;
	assign m_awaddr = rx_addr;
	assign m_bready = rx_st == R_RESP;
	assign rx_done = rx_st == R_RESP && m_bvalid && rx_eof_seen;
	// receive sequencer: classify, pack words, pad the burst out
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_st <= R_IDLE;
			rx_eof_seen <= 1'b0;
			rx_nondata <= 1'b0;
			rx_idx <= 3'h0;
			rx_beat <= 4'h0;
			rx_addr <= REG_RESET;
			m_wdata <= '0;
			m_wvalid <= 1'b0;
		end else if (sreset) begin
			rx_st <= R_IDLE;
			rx_idx <= 3'h0; // a cut frame must not leave the packer mid-beat
			m_wvalid <= 1'b0;
		end else begin
			if (rx_push) begin
				m_wdata <= {(rx_word ? rx_data : 32'h0000_0000), m_wdata[DMA_W-1:WORD_W]};
				rx_idx <= rx_idx + 3'h1;
				m_wvalid <= rx_idx == 3'h7;
			end else if (m_wvalid && m_wready) begin
				m_wvalid <= 1'b0;
			end
			unique case (rx_st)
				R_IDLE: if (rx_word) begin
					rx_nondata <= rx_data[7:0] != FIS_TYPE_DATA;
					rx_addr <= rx_data[7:0] == FIS_TYPE_DATA ? cfg.d_base : cfg.nd_base;
					rx_eof_seen <= rx_eof;
					rx_beat <= 4'h0;
					rx_st <= R_AW;
				end
				R_AW: if (m_awready) begin
					rx_st <= R_FILL;
				end
				R_FILL: begin
					if (rx_word && rx_eof) begin
						rx_eof_seen <= 1'b1;
					end
					if (m_wvalid && m_wready) begin
						rx_beat <= rx_beat + 4'h1;
						if (m_wlast) begin
							rx_st <= R_RESP;
						end
					end
				end
				R_RESP: if (m_bvalid) begin
					rx_st <= rx_eof_seen ? R_IDLE : R_AW;
					if (!rx_eof_seen) begin
						rx_addr <= rx_addr + BURST_BYTES;
					end
				end
			endcase
		end
	end
	// status and interrupts; a new event wins over a clear in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_cnt_reg <= '0;
			rx_cnt_type_reg <= 1'b0;
			err_reg <= REG_RESET;
			core_to_cpu_irq <= 1'b0;
			cpu_to_core_irq <= 1'b0;
		end else begin
			rx_cnt_reg <= (cfg.ctrl_wr ? '0 : rx_cnt_reg) + CNT_W'(rx_word);
			if (rx_done) begin
				rx_cnt_type_reg <= rx_nondata;
			end else if (cfg.clr_type) begin
				rx_cnt_type_reg <= 1'b0;
			end
			if (tx_done || rx_done) begin
				err_reg <= link_err_code;
			end
			if (rx_done) begin
				core_to_cpu_irq <= 1'b1;
			end else if (cfg.clr_c2c) begin
				core_to_cpu_irq <= 1'b0;
			end
			if (tx_done) begin
				cpu_to_core_irq <= 1'b1;
			end else if (cfg.clr_p2c) begin
				cpu_to_core_irq <= 1'b0;
			end
		end
	end
	a_hdr_first: assert property (@(posedge clk) disable iff (rst)
		tx_start && cfg.ctrl_val[CTRL_DATA_BIT] |=> tx_valid && tx_sof && tx_data == DATA_FIS_HDR)
		else $error("data header not sent first");
	a_ar_hold: assert property (@(posedge clk) disable iff (rst || sreset)
		m_arvalid && !m_arready |=> m_arvalid && $stable(m_araddr)) else $error("ar dropped");
	// the beat counter must wrap exactly at the sixteenth beat and stop the data phase
	a_wlast_beat: assert property (@(posedge clk) disable iff (rst || sreset)
		m_wvalid && m_wready && m_wlast |=> rx_beat == 4'h0 && rx_st == R_RESP && !m_wvalid)
		else $error("burst not 16 beats");
	a_count_clear: assert property (@(posedge clk) disable iff (rst)
		cfg.ctrl_wr && !rx_word |=> rx_cnt_reg == '0) else $error("count not cleared");
	a_rx_irq: assert property (@(posedge clk) disable iff (rst)
		rx_done |=> core_to_cpu_irq && rx_cnt_type_reg == $past(rx_nondata))
		else $error("reception completion not flagged");
	a_tx_irq_clear: assert property (@(posedge clk) disable iff (rst)
		cfg.clr_p2c && !tx_done |=> !cpu_to_core_irq) else $error("irq not cleared");
	a_err_capture: assert property (@(posedge clk) disable iff (rst)
		tx_done |=> err_reg == $past(link_err_code)) else $error("error code missed");
	a_soft_reset: assert property (@(posedge clk) disable iff (rst)
		sreset ##1 sreset |-> !m_arvalid && !tx_valid && !m_awvalid) else $error("not held");
	// a stalled beat must not be overwritten by a newly packed word
	a_rx_stall: assert property (@(posedge clk) disable iff (rst || sreset)
		m_wvalid && !m_wready |=> m_wvalid && $stable(m_wdata))
		else $error("word taken over full beat");
endmodule : ftc_transport_controller
`default_nettype wire

/* File: ftc_pkg.sv */
// Purpose: shared constants of the fis transport controller
// Assumes: 32-bit link words, 256-bit memory beats
// Notes: offsets are byte addresses on the axi4-lite port
package ftc_pkg;
	// data path widths
	localparam int WORD_W = 32;
	localparam int DMA_W = 256;
	localparam int WORDS_PER_BEAT = DMA_W / WORD_W;
	localparam int CNT_W = 24;
	localparam int CTRL_CNT_W = 16;
	// register offsets, read meaning / write meaning
	localparam logic [4:0] OFS_TX_BASE = 5'h00;
	localparam logic [4:0] OFS_ERR_ND = 5'h04;
	localparam logic [4:0] OFS_CTRL = 5'h08;
	localparam logic [4:0] OFS_CNT_D = 5'h0C;
	localparam logic [4:0] OFS_VER_ACK = 5'h10;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	// control fields
	localparam int CTRL_RESET_BIT = 31;
	localparam int CTRL_START_BIT = 30;
	localparam int CTRL_DATA_BIT = 29;
	// acknowledge fields
	localparam int ACK_C2C_BIT = 31;
	localparam int ACK_P2C_BIT = 30;
	localparam int ACK_TYPE_BIT = 29;
	// receive count fields
	localparam int CNT_TYPE_BIT = 31;
	// axi4 burst shape
	localparam logic [3:0] LAST_BEAT = 4'hF;
	localparam logic [7:0] AXI_LEN = 8'h0F;
	localparam logic [2:0] AXI_SIZE = 3'h5;
	localparam logic [1:0] AXI_INCR = 2'h1;
	localparam logic [31:0] BURST_BYTES = 32'h0000_0200;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// fis header
	localparam logic [7:0] FIS_TYPE_DATA = 8'h46;
	localparam logic [31:0] DATA_FIS_HDR = 32'h0000_0046;
endpackage : ftc_pkg

/* File: ftc_regs_if.sv */
// Purpose: register values between bank and transfer core
// Assumes: single clock domain
// Notes: pulses last one cycle
`timescale 1ns/1ps
`default_nettype none
interface ftc_regs_if;
	logic [31:0] tx_base;
	logic [31:0] nd_base;
	logic [31:0] d_base;
	logic [31:0] ctrl_val;
	logic ctrl_wr;
	logic clr_c2c;
	logic clr_p2c;
	logic clr_type;
	logic [31:0] err_code;
	logic [31:0] version;
	logic rx_type;
	logic [23:0] rx_count;
	modport bank(output tx_base, nd_base, d_base, ctrl_val, ctrl_wr, clr_c2c, clr_p2c,
		clr_type, input err_code, version, rx_type, rx_count);
	modport core(input tx_base, nd_base, d_base, ctrl_val, ctrl_wr, clr_c2c, clr_p2c,
		clr_type, output err_code, version, rx_type, rx_count);
endinterface : ftc_regs_if
`default_nettype wire

/* File: ftc_reg_bank.sv */
// Purpose: axi4-lite slave holding the controller registers
// Assumes: address and data of a write arrive together
// Notes: same offset reads status, writes setup
`timescale 1ns/1ps
`default_nettype none
module ftc_reg_bank #(parameter int ADDR_W = 8) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// axi4-lite slave
	input wire logic [ADDR_W-1:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [ADDR_W-1:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	// register values
	ftc_regs_if.bank cfg
);
	import ftc_pkg::*;
	logic wr_go;
	logic rd_go;
	logic wr_hit;
	logic [4:0] wofs;
	logic [4:0] rofs;
	logic [31:0] wmask;
	if (ADDR_W < 5) begin : g_bad_width
		$error("ADDR_W too small for the register map");
	end
	// one write per response; stalls until bresp is taken
	assign wr_go = s_awvalid && s_wvalid && !s_bvalid;
	assign s_awready = wr_go;
	assign s_wready = wr_go;
	assign rd_go = s_arvalid && !s_rvalid;
	assign s_arready = rd_go;
	assign wofs = s_awaddr[4:0];
	assign rofs = s_araddr[4:0];
	assign wr_hit = (s_awaddr >> 5) == '0 && wofs[1:0] == 2'h0 && wofs <= OFS_VER_ACK;
	assign wmask = {{8{s_wstrb[3]}}, {8{s_wstrb[2]}}, {8{s_wstrb[1]}}, {8{s_wstrb[0]}}};
	// setup registers, byte lanes honoured
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg.tx_base <= REG_RESET;
			cfg.nd_base <= REG_RESET;
			cfg.d_base <= REG_RESET;
			cfg.ctrl_val <= REG_RESET;
		end else if (wr_go && wr_hit) begin
			unique case (wofs)
				OFS_TX_BASE: cfg.tx_base <= (cfg.tx_base & ~wmask) | (s_wdata & wmask);
				OFS_ERR_ND: cfg.nd_base <= (cfg.nd_base & ~wmask) | (s_wdata & wmask);
				OFS_CTRL: cfg.ctrl_val <= (cfg.ctrl_val & ~wmask) | (s_wdata & wmask);
				OFS_CNT_D: cfg.d_base <= (cfg.d_base & ~wmask) | (s_wdata & wmask);
				default: ;
			endcase
		end
	end
	// command pulses, aligned with the stored control value
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg.ctrl_wr <= 1'b0;
			cfg.clr_c2c <= 1'b0;
			cfg.clr_p2c <= 1'b0;
			cfg.clr_type <= 1'b0;
		end else begin
			cfg.ctrl_wr <= wr_go && wr_hit && wofs == OFS_CTRL;
			cfg.clr_c2c <= wr_go && wr_hit && wofs == OFS_VER_ACK && s_wdata[ACK_C2C_BIT];
			cfg.clr_p2c <= wr_go && wr_hit && wofs == OFS_VER_ACK && s_wdata[ACK_P2C_BIT];
			cfg.clr_type <= wr_go && wr_hit && wofs == OFS_VER_ACK && s_wdata[ACK_TYPE_BIT];
		end
	end
	// write response
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_bvalid <= 1'b0;
			s_bresp <= RESP_OKAY;
		end else if (wr_go) begin
			s_bvalid <= 1'b1;
			s_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_bready) begin
			s_bvalid <= 1'b0;
		end
	end
	// read data; write-only offsets answer slverr with zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_rvalid <= 1'b0;
			s_rdata <= REG_RESET;
			s_rresp <= RESP_OKAY;
		end else if (rd_go) begin
			s_rvalid <= 1'b1;
			s_rresp <= RESP_OKAY;
			s_rdata <= REG_RESET;
			if ((s_araddr >> 5) != '0) begin
				s_rresp <= RESP_SLVERR;
			end else begin
				unique case (rofs)
					OFS_ERR_ND: s_rdata <= cfg.err_code;
					OFS_CNT_D: s_rdata <= {cfg.rx_type, 7'h00, cfg.rx_count};
					OFS_VER_ACK: s_rdata <= cfg.version;
					default: s_rresp <= RESP_SLVERR;
				endcase
			end
		end else if (s_rready) begin
			s_rvalid <= 1'b0;
		end
	end
	a_bresp_hold: assert property (@(posedge clk) disable iff (rst)
		s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp)) else $error("bresp dropped");
endmodule : ftc_reg_bank
`default_nettype wire

/* File: ftc_far_model.sv */
// Purpose: far side stand-in: axi4 memory slave and link transmit sink
// Assumes: one clock; slow makes rvalid, wready and tx_ready of the model run at half rate
// Notes: read data word equals its own byte address, so payload is predictable
`timescale 1ns/1ps
`default_nettype none
module ftc_far_model (
	// clock, reset, pacing
	input wire logic clk,
	input wire logic rst,
	input wire logic slow,
	// axi4 read channels
	input wire logic [31:0] m_araddr,
	input wire logic m_arvalid,
	output logic m_arready,
	output logic [ftc_pkg::DMA_W-1:0] m_rdata,
	output logic m_rlast,
	output logic m_rvalid,
	input wire logic m_rready,
	// axi4 write channels
	input wire logic [31:0] m_awaddr,
	input wire logic m_awvalid,
	output logic m_awready,
	input wire logic [ftc_pkg::DMA_W-1:0] m_wdata,
	input wire logic m_wlast,
	input wire logic m_wvalid,
	output logic m_wready,
	output logic [1:0] m_bresp,
	output logic m_bvalid,
	input wire logic m_bready,
	// link transmit side
	input wire logic [31:0] tx_data,
	input wire logic tx_sof,
	input wire logic tx_eof,
	input wire logic tx_valid,
	output logic tx_ready
);
	import ftc_pkg::*;
	logic tick, rd_on, wr_on, b_on;
	logic [31:0] raddr;
	logic [3:0] rbeat;
	logic [DMA_W-1:0] beat;
	logic [33:0] txq[$];
	logic [31:0] ar_q[$];
	logic [31:0] aw_q[$];
	logic [DMA_W:0] w_q[$];
	// beat content from address; inverted while not valid so stale data never matches
	always_comb begin
		for (int i = 0; i < WORDS_PER_BEAT; i++) begin
			beat[i*32 +: 32] = raddr + {rbeat, 5'h00} + 32'(i * 4);
		end
	end
	assign m_rvalid = rd_on && (!slow || tick);
	assign m_rdata = m_rvalid ? beat : ~beat;
	assign m_rlast = (rbeat == LAST_BEAT);
	assign m_arready = !rd_on;
	assign m_awready = !wr_on;
	assign m_wready = wr_on && !b_on && (!slow || tick);
	assign m_bvalid = b_on;
	assign m_bresp = RESP_OKAY;
	assign tx_ready = !slow || tick;
	// one burst at a time per direction; logs what the block sent
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			tick <= 1'b0;
			rd_on <= 1'b0;
			wr_on <= 1'b0;
			b_on <= 1'b0;
			raddr <= 32'h0000_0000;
			rbeat <= 4'h0;
		end else begin
			tick <= !tick;
			if (m_arvalid && m_arready) begin
				rd_on <= 1'b1;
				raddr <= m_araddr;
				rbeat <= 4'h0;
				ar_q.push_back(m_araddr);
			end
			if (m_rvalid && m_rready) begin
				rbeat <= rbeat + 4'h1;
				if (m_rlast) rd_on <= 1'b0;
			end
			if (m_awvalid && m_awready) begin
				wr_on <= 1'b1;
				aw_q.push_back(m_awaddr);
			end
			if (m_wvalid && m_wready) begin
				w_q.push_back({m_wlast, m_wdata});
				if (m_wlast) b_on <= 1'b1;
			end
			if (m_bvalid && m_bready) begin
				b_on <= 1'b0;
				wr_on <= 1'b0;
			end
			if (tx_valid && tx_ready) txq.push_back({tx_sof, tx_eof, tx_data});
		end
	end
endmodule : ftc_far_model
`default_nettype wire

/* File: ftc_transport_controller_bench.sv */
// Purpose: self-checking bench of the fis transport controller
// Assumes: far model on memory and transmit side; bench drives the receive link
// Notes: inputs change on the falling edge; every wait is bounded
`timescale 1ns/1ps
`default_nettype none
module ftc_transport_controller_bench;
	import ftc_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic slow = 1'b0;
	logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
	logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
	logic [31:0] s_wdata = 32'h0000_0000;
	logic [3:0] s_wstrb = 4'hF;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [1:0] s_bresp, s_rresp, m_arburst, m_awburst, m_bresp;
	logic [31:0] s_rdata, m_araddr, m_awaddr, tx_data;
	logic [7:0] m_arlen, m_awlen;
	logic [2:0] m_arsize, m_awsize;
	logic m_arvalid, m_arready, m_rlast, m_rvalid, m_rready, m_awvalid, m_awready;
	logic [DMA_W-1:0] m_rdata, m_wdata;
	logic [DMA_W/8-1:0] m_wstrb;
	logic m_wlast, m_wvalid, m_wready, m_bvalid, m_bready;
	logic tx_sof, tx_eof, tx_valid, tx_ready, rx_ready, link_reset;
	logic core_to_cpu_irq, cpu_to_core_irq;
	logic [31:0] rx_data = 32'h0000_0000, link_err_code = 32'h0000_0000;
	logic [31:0] link_version = 32'h0102_0304;
	logic rx_sof = 1'b0, rx_eof = 1'b0, rx_valid = 1'b0;
	int err_total = 0, n_tests = 0;
	always #2 clk = ~clk;
	ftc_transport_controller dut_u (.*);
	ftc_far_model far_u (.*);
	// verdict and end of run
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// returns mid-cycle with s high, before the edge that takes it
	task automatic wait_on(ref logic s, input int lim);
		for (int k = 0; k < lim; k++) begin
			#1;
			if (s === 1'b1) return;
			@(negedge clk);
		end
		err_total++;
		$display("mismatch wait expected high seen timeout");
		finish_test();
	endtask : wait_on
	task automatic lw(input logic [4:0] a, input logic [31:0] d, input logic [1:0] rs);
		@(negedge clk);
		s_awaddr = {3'h0, a};
		s_wdata = d;
		s_awvalid = 1'b1;
		s_wvalid = 1'b1;
		wait_on(s_awready, 50);
		@(negedge clk);
		s_awvalid = 1'b0;
		s_wvalid = 1'b0;
		s_wdata = ~d;
		s_bready = 1'b1;
		wait_on(s_bvalid, 50);
		chk("bresp", rs, s_bresp);
		@(negedge clk);
		s_bready = 1'b0;
	endtask : lw
	task automatic lr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] rs);
		@(negedge clk);
		s_araddr = {3'h0, a};
		s_arvalid = 1'b1;
		wait_on(s_arready, 50);
		@(negedge clk);
		s_arvalid = 1'b0;
		s_rready = 1'b1;
		wait_on(s_rvalid, 50);
		chk("rresp", rs, s_rresp);
		chk("rdata", d, s_rdata);
		@(negedge clk);
		s_rready = 1'b0;
	endtask : lr
	// payload word i is D0000000 plus i, word 0 is the header
	task automatic rx_frame(input logic [31:0] hdr, input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			rx_data = (i == 0) ? hdr : 32'hD000_0000 + 32'(i);
			rx_sof = (i == 0);
			rx_eof = (i == n - 1);
			rx_valid = 1'b1;
			wait_on(rx_ready, 200);
		end
		@(negedge clk);
		rx_valid = 1'b0;
		rx_sof = 1'b0;
		rx_eof = 1'b0;
		rx_data = ~rx_data;
	endtask : rx_frame
	// memory words carry their own address, header only for data frames
	task automatic tx_check(input logic [31:0] base, input int n, input int hdr);
		int m;
		logic [31:0] w;
		m = n + hdr;
		wait_on(cpu_to_core_irq, 3000);
		chk("tx count", m, far_u.txq.size());
		chk("read addr", base, far_u.ar_q[0]);
		for (int i = 0; i < m; i++) begin
			w = (hdr == 1 && i == 0) ? DATA_FIS_HDR : base + 32'((i - hdr) * 4);
			chk("tx word", {i == 0, i == m - 1, w}, far_u.txq[i]);
		end
	endtask : tx_check
	task automatic t_reset();
		chk("idle outputs", 40'h01, {core_to_cpu_irq, cpu_to_core_irq, link_reset, m_arvalid,
			m_awvalid, tx_valid, rx_ready});
		lr(OFS_VER_ACK, link_version, RESP_OKAY);
		lr(OFS_CNT_D, 32'h0000_0000, RESP_OKAY);
		lr(OFS_TX_BASE, 32'h0000_0000, RESP_SLVERR);
		lr(5'h14, 32'h0000_0000, RESP_SLVERR);
		lw(5'h14, 32'hFFFF_FFFF, RESP_SLVERR);
		$display("test reset done");
	endtask : t_reset
	task automatic t_tx_data();
		slow = 1'b1;
		link_err_code = 32'hE000_0005;
		lw(OFS_TX_BASE, 32'h0000_0200, RESP_OKAY);
		lw(OFS_CTRL, 32'h6000_0081, RESP_OKAY);
		tx_check(32'h0000_0200, 129, 1);
		chk("second burst", 32'h0000_0400, far_u.ar_q[1]);
		chk("burst len", AXI_LEN, m_arlen);
		lr(OFS_ERR_ND, 32'hE000_0005, RESP_OKAY);
		lw(OFS_VER_ACK, 32'h8000_0000, RESP_OKAY);
		chk("p2c kept", 1, cpu_to_core_irq);
		lw(OFS_VER_ACK, 32'h4000_0000, RESP_OKAY);
		chk("p2c cleared", 0, cpu_to_core_irq);
		$display("test transmit data done");
	endtask : t_tx_data
	task automatic t_tx_nondata();
		slow = 1'b0;
		far_u.txq.delete();
		far_u.ar_q.delete();
		lw(OFS_TX_BASE, 32'h0000_0800, RESP_OKAY);
		lw(OFS_CTRL, 32'h4000_0003, RESP_OKAY);
		tx_check(32'h0000_0800, 3, 0);
		lw(OFS_VER_ACK, 32'h4000_0000, RESP_OKAY);
		// data frame of zero words: header alone carries both frame marks
		far_u.txq.delete();
		lw(OFS_CTRL, 32'h6000_0000, RESP_OKAY);
		wait_on(cpu_to_core_irq, 100);
		chk("hdr only count", 1, far_u.txq.size());
		chk("hdr only", {2'b11, DATA_FIS_HDR}, far_u.txq[0]);
		lw(OFS_VER_ACK, 32'h4000_0000, RESP_OKAY);
		$display("test transmit non-data done");
	endtask : t_tx_nondata
	task automatic t_rx();
		logic [DMA_W:0] bt;
		logic [31:0] w;
		slow = 1'b1;
		link_err_code = 32'hE000_0007;
		lw(OFS_CNT_D, 32'h0000_0400, RESP_OKAY);
		lw(OFS_ERR_ND, 32'h0000_0600, RESP_OKAY);
		rx_frame(DATA_FIS_HDR, 10);
		wait_on(core_to_cpu_irq, 3000);
		chk("data area", 32'h0000_0400, far_u.aw_q[0]);
		chk("beats", 16, far_u.w_q.size());
		chk("burst shape", {AXI_LEN, AXI_SIZE, AXI_INCR, AXI_SIZE, AXI_INCR},
			{m_awlen, m_awsize, m_awburst, m_arsize, m_arburst});
		chk("wstrb", 32'hFFFF_FFFF, m_wstrb);
		for (int i = 0; i < 128; i++) begin
			bt = far_u.w_q[i / 8];
			w = (i == 0) ? DATA_FIS_HDR : (i < 10) ? 32'hD000_0000 + 32'(i) : 32'h0000_0000;
			chk("rx word", {i / 8 == 15, w}, {bt[DMA_W], bt[(i % 8) * 32 +: 32]});
		end
		lr(OFS_CNT_D, 32'h0000_000A, RESP_OKAY);
		lr(OFS_ERR_ND, 32'hE000_0007, RESP_OKAY);
		lw(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
		lr(OFS_CNT_D, 32'h0000_0000, RESP_OKAY);
		lw(OFS_VER_ACK, 32'h8000_0000, RESP_OKAY);
		chk("c2c cleared", 0, core_to_cpu_irq);
		far_u.aw_q.delete();
		rx_frame(32'h0000_0027, 2);
		wait_on(core_to_cpu_irq, 3000);
		chk("non-data area", 32'h0000_0600, far_u.aw_q[0]);
		lr(OFS_CNT_D, 32'h8000_0002, RESP_OKAY);
		lw(OFS_VER_ACK, 32'hA000_0000, RESP_OKAY);
		lr(OFS_CNT_D, 32'h0000_0002, RESP_OKAY);
		chk("c2c low", 0, core_to_cpu_irq);
		$display("test receive done");
	endtask : t_rx
	task automatic t_soft();
		lw(OFS_CTRL, 32'h8000_0000, RESP_OKAY);
		chk("held", 2'b11, {link_reset, rx_ready});
		lw(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
		chk("released", 0, link_reset);
		$display("test soft reset done");
	endtask : t_soft
	// main sequence: reset, then each scenario
	initial begin
		repeat (12) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		t_reset();
		t_tx_data();
		t_tx_nondata();
		t_rx();
		t_soft();
		finish_test();
	end
endmodule : ftc_transport_controller_bench
`default_nettype wire
